/* File: rtl/spict_top.sv */
// transmit fifo and clock-phase-1 serial controller sequencer
//
// Operation
// - controller bit 0 enables driving the bus only while format bit 16 is set
// - format bit 16 selects clock phase 1
// - period is prescale plus one bus clocks
// - prescale zero gives two bus-clock period
// - format bit 17 sets serial clock idle level
// - lead: half period, c2t delay, two cycles
// - polarity 1 with hold: three extra cycles
// - chip select held t2c plus one cycles
// - both delays come from delay register fields
`timescale 1ns/1ps

module spict_fifo #(
    parameter int unsigned W     = 16,
    parameter int unsigned DEPTH = 8
) (
    input  wire logic         CLOCK,
    input  wire logic         SRST,
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    localparam int unsigned AW = $clog2(DEPTH);

    // whole fifo state, storage included
    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;      // word storage
        logic [AW-1:0]           wr_ptr;   // next write slot
        logic [AW-1:0]           rd_ptr;   // next read slot
        logic [AW:0]             count;    // words held
        logic                    full;     // registered full flag
        logic                    empty;    // registered empty flag
        logic                    room;     // registered not-full, drives the ready port
    } fifo_st_s;

    fifo_st_s st_ff;     // registered state
    fifo_st_s nxt_st;    // next state
    logic     push;      // accepted write
    logic     pop;       // accepted read

    assign in_ready  = st_ff.room;
    assign out_valid = ~st_ff.empty;
    assign out_data  = st_ff.mem[st_ff.rd_ptr];
    assign push      = in_valid & ~st_ff.full;
    assign pop       = out_ready & ~st_ff.empty;

    // pointer and count update; flags registered so the ready port is a flop
    always_comb begin
        nxt_st = st_ff;
        if (push) begin
            nxt_st.mem[st_ff.wr_ptr] = in_data;
            nxt_st.wr_ptr            = st_ff.wr_ptr + AW'(1);
        end
        if (pop) begin
            nxt_st.rd_ptr = st_ff.rd_ptr + AW'(1);
        end
        // simultaneous push and pop leaves the count alone
        if (push && !pop) begin
            nxt_st.count = st_ff.count + (AW+1)'(1);
        end else if (pop && !push) begin
            nxt_st.count = st_ff.count - (AW+1)'(1);
        end
        nxt_st.full  = (nxt_st.count == (AW+1)'(DEPTH));
        nxt_st.empty = (nxt_st.count == '0);
        nxt_st.room  = ~nxt_st.full;
    end

    // state register
    always_ff @(posedge CLOCK) begin
        if (SRST) begin
            st_ff       <= '0;
            st_ff.empty <= 1'b1;
            st_ff.room  <= 1'b1;
        end else begin
            st_ff <= nxt_st;
        end
    end
endmodule // spict_fifo

module spict_top
    import spict_pkg::*;
#(
    parameter int unsigned WORD_W     = 16,
    parameter int unsigned FIFO_DEPTH = 8
) (
    input  wire logic              CLOCK,
    input  wire logic              SRST,
    input  wire logic [31:0]       GLOBAL_CONTROL_REG,
    input  wire logic [31:0]       FORMAT_REG,
    input  wire logic [31:0]       DELAY_REG,
    input  wire logic              CS_HOLD_BETWEEN_WORDS,
    input  wire logic [WORD_W-1:0] TX_DATA,
    input  wire logic              TX_VALID,
    output logic                   TX_READY,
    output logic [WORD_W-1:0]      RX_DATA,
    output logic                   RX_VALID,
    output logic                   BUSY,
    output logic                   SERIAL_CLOCK_PIN,
    output logic                   CONTROLLER_OUT_LINE,
    output logic                   CONTROLLER_OUT_OE,
    input  wire logic              CONTROLLER_IN_LINE,
    output logic                   CS_N
);
    import spict_pkg::*;

    localparam int unsigned BW = $clog2(WORD_W + 1);

    // whole sequencer state
    typedef struct packed {
        spict_state_e      state;   // sequencer state
        logic [9:0]        cnt;     // bus cycles left in current phase
        logic              half;    // 0: after leading edge, 1: after trailing
        logic [BW-1:0]     bitcnt;  // bits completed in the word
        logic [WORD_W-1:0] tx_sh;   // outgoing shift register
        logic [WORD_W-1:0] rx_sh;   // incoming shift register
        logic [WORD_W-1:0] rx_data; // last received word
        logic              rx_val;  // one-cycle word pulse
        logic              sclk;    // serial clock pin
        logic              mosi;    // data output pin
        logic              oe;      // pins driven
        logic              cs_n;    // chip select, active low
        logic              busy;    // not idle, kept as a flop for the port
    } core_st_s;

    core_st_s          st_ff;      // registered state
    core_st_s          nxt_st;     // next state
    spict_cfg_s        cfg;        // decoded configuration
    logic              fifo_valid; // a word waits
    logic              fifo_pop;   // take the waiting word
    logic [WORD_W-1:0] fifo_data;  // waiting word
    logic              go;         // start allowed
    logic [9:0]        period;     // serial period in bus clocks
    logic [9:0]        half1;      // first half period
    logic [9:0]        half2;      // second half period
    logic [9:0]        lead;       // cs to first edge count
    logic [9:0]        trail;      // last edge to cs release count

    // register fields pulled apart in one place
    always_comb begin
        cfg.enable                = GLOBAL_CONTROL_REG[CTRL_EN_BIT];
        cfg.phase                 = FORMAT_REG[FMT_PHASE_BIT];
        cfg.polarity              = FORMAT_REG[FMT_POL_BIT];
        cfg.prescale_value        = FORMAT_REG[FMT_PRESC_MSB:FMT_PRESC_LSB];
        cfg.cs_to_clock_delay     = DELAY_REG[DLY_C2T_MSB:DLY_C2T_LSB];
        cfg.clock_to_cs_delay     = DELAY_REG[DLY_T2C_MSB:DLY_T2C_LSB];
        cfg.cs_hold_between_words = CS_HOLD_BETWEEN_WORDS;
    end

    // transmit buffer; its full flag throttles the word source
    spict_fifo #(
        .W     (WORD_W),
        .DEPTH (FIFO_DEPTH)
    ) u_txq (
        .CLOCK     (CLOCK),
        .SRST      (SRST),
        .in_valid  (TX_VALID),
        .in_ready  (TX_READY),
        .in_data   (TX_DATA),
        .out_valid (fifo_valid),
        .out_ready (fifo_pop),
        .out_data  (fifo_data)
    );

    // period split and chip-select delays; odd periods give the extra cycle
    // to the second half, which keeps both halves within one bus cycle
    always_comb begin
        period = {2'b00, cfg.prescale_value} + 10'h001;
        if (cfg.prescale_value == 8'h00) begin
            period = PRESC0_PERIOD;
        end
        half1 = period >> 1;
        half2 = period - half1;
        lead  = half1 + {2'b00, cfg.cs_to_clock_delay} + LEAD_EXTRA;
        if (cfg.cs_hold_between_words && cfg.polarity) begin
            lead = half1 + {2'b00, cfg.cs_to_clock_delay} + LEAD_EXTRA_HLD;
        end
        trail = {2'b00, cfg.clock_to_cs_delay} + TRAIL_EXTRA;
    end

    // only controller mode with phase 1 runs
    assign go = cfg.enable & cfg.phase;

    // sequencer; counts load with n-1 so an event lands n edges later
    always_comb begin
        nxt_st        = st_ff;
        fifo_pop      = 1'b0;
        nxt_st.rx_val = 1'b0;
        nxt_st.oe     = go;
        case (st_ff.state)
            ST_IDLE: begin
                // clock rests at its idle level
                nxt_st.sclk = cfg.polarity;
                nxt_st.cs_n = 1'b1;
                if (go && fifo_valid) begin
                    fifo_pop      = 1'b1;
                    nxt_st.tx_sh  = fifo_data;
                    nxt_st.cs_n   = 1'b0;
                    nxt_st.cnt    = lead - 10'h001;
                    nxt_st.bitcnt = '0;
                    nxt_st.state  = ST_LEAD;
                end
            end
            ST_LEAD: begin
                if (st_ff.cnt == 10'h000) begin
                    // leading edge drives the first bit
                    nxt_st.sclk  = ~st_ff.sclk;
                    nxt_st.mosi  = st_ff.tx_sh[WORD_W-1];
                    nxt_st.tx_sh = {st_ff.tx_sh[WORD_W-2:0], 1'b0};
                    nxt_st.half  = 1'b0;
                    nxt_st.cnt   = half1 - 10'h001;
                    nxt_st.state = ST_SHIFT;
                end else begin
                    nxt_st.cnt = st_ff.cnt - 10'h001;
                end
            end
            ST_SHIFT: begin
                if (st_ff.cnt != 10'h000) begin
                    nxt_st.cnt = st_ff.cnt - 10'h001;
                end else if (!st_ff.half) begin
                    nxt_st.sclk   = ~st_ff.sclk;
                    nxt_st.rx_sh  = {st_ff.rx_sh[WORD_W-2:0], CONTROLLER_IN_LINE};
                    nxt_st.bitcnt = st_ff.bitcnt + BW'(1);
                    nxt_st.half   = 1'b1;
                    nxt_st.cnt    = half2 - 10'h001;
                    if (st_ff.bitcnt == BW'(WORD_W - 1)) begin
                        // last edge: word complete, start chip-select hold
                        nxt_st.rx_data = {st_ff.rx_sh[WORD_W-2:0], CONTROLLER_IN_LINE};
                        nxt_st.rx_val  = 1'b1;
                        // hold count loads at final edge
                        nxt_st.cnt     = trail - 10'h001;
                        nxt_st.state   = ST_TRAIL;
                    end
                end else begin
                    // next leading edge drives next bit
                    nxt_st.sclk  = ~st_ff.sclk;
                    nxt_st.mosi  = st_ff.tx_sh[WORD_W-1];
                    nxt_st.tx_sh = {st_ff.tx_sh[WORD_W-2:0], 1'b0};
                    nxt_st.half  = 1'b0;
                    nxt_st.cnt   = half1 - 10'h001;
                end
            end
            ST_TRAIL: begin
                if (st_ff.cnt != 10'h000) begin
                    nxt_st.cnt = st_ff.cnt - 10'h001;
                end else if (go && cfg.cs_hold_between_words && fifo_valid) begin
                    // chip select kept, next word leads in
                    fifo_pop      = 1'b1;
                    nxt_st.tx_sh  = fifo_data;
                    nxt_st.cnt    = lead - 10'h001;
                    nxt_st.bitcnt = '0;
                    nxt_st.state  = ST_LEAD;
                end else begin
                    nxt_st.cs_n  = 1'b1;
                    nxt_st.state = ST_IDLE;
                end
            end
            default: begin
                nxt_st.cs_n  = 1'b1;
                nxt_st.state = ST_IDLE;
            end
        endcase
        // losing controller mode aborts; a partial word is dropped
        if (!go) begin
            nxt_st.cs_n  = 1'b1;
            nxt_st.sclk  = cfg.polarity;
            nxt_st.state = ST_IDLE;
        end
        // busy registered so the port comes straight from a flop
        nxt_st.busy = (nxt_st.state != ST_IDLE);
    end

    // state register
    always_ff @(posedge CLOCK) begin
        if (SRST) begin
            st_ff       <= '0;
            st_ff.state <= ST_IDLE;
            st_ff.cs_n  <= CS_N_RST;
            st_ff.sclk  <= SCLK_RST;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // every output straight from a state flop
    assign RX_DATA             = st_ff.rx_data;
    assign RX_VALID            = st_ff.rx_val;
    assign BUSY                = st_ff.busy;
    assign SERIAL_CLOCK_PIN    = st_ff.sclk;
    assign CONTROLLER_OUT_LINE = st_ff.mosi;
    assign CONTROLLER_OUT_OE   = st_ff.oe;
    assign CS_N                = st_ff.cs_n;
endmodule // spict_top

/* File: rtl/spict_pkg.sv */
// shared constants and carrier types of the serial controller with clock phase 1
package spict_pkg;
    // global control register field
    localparam int unsigned CTRL_EN_BIT    = 0;
    // format register fields
    localparam int unsigned FMT_PHASE_BIT  = 16;
    localparam int unsigned FMT_POL_BIT    = 17;
    localparam int unsigned FMT_PRESC_LSB  = 8;
    localparam int unsigned FMT_PRESC_MSB  = 15;
    // delay register fields
    localparam int unsigned DLY_C2T_LSB    = 24;
    localparam int unsigned DLY_C2T_MSB    = 31;
    localparam int unsigned DLY_T2C_LSB    = 16;
    localparam int unsigned DLY_T2C_MSB    = 23;
    // timing counts in bus-clock cycles
    localparam logic [9:0]  PRESC0_PERIOD  = 10'h002;
    localparam logic [9:0]  LEAD_EXTRA     = 10'h002;
    localparam logic [9:0]  LEAD_EXTRA_HLD = 10'h003;
    localparam logic [9:0]  TRAIL_EXTRA    = 10'h001;
    // reset values of the pins
    localparam logic        CS_N_RST       = 1'b1;
    localparam logic        SCLK_RST       = 1'b0;

    // decoded configuration travelling together
    typedef struct packed {
        logic       enable;
        logic       phase;
        logic       polarity;
        logic [7:0] prescale_value;
        logic [7:0] cs_to_clock_delay;
        logic [7:0] clock_to_cs_delay;
        logic       cs_hold_between_words;
    } spict_cfg_s;

    // sequencer states, gray along idle, lead, shift, trail
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_LEAD  = 2'b01,
        ST_SHIFT = 2'b11,
        ST_TRAIL = 2'b10
    } spict_state_e;
endpackage

/* File: verification/spict_properties.sv */
// pin timing checks for the clock-phase-1 serial controller
`timescale 1ns/1ps
module spict_checker
    import spict_pkg::*;
(
    input wire logic        CLOCK,
    input wire logic        SRST,
    input wire logic [31:0] GLOBAL_CONTROL_REG,
    input wire logic [31:0] FORMAT_REG,
    input wire logic [31:0] DELAY_REG,
    input wire logic        CS_HOLD_BETWEEN_WORDS,
    input wire logic        TX_READY,
    input wire logic        RX_VALID,
    input wire logic        SERIAL_CLOCK_PIN,
    input wire logic        CONTROLLER_OUT_LINE,
    input wire logic        CONTROLLER_OUT_OE,
    input wire logic        CS_N
);
    logic       pol;    // idle level of the clock
    logic       on;     // enable and phase both set
    logic [9:0] per;    // serial period in bus clocks
    logic [9:0] lead;   // chip select fall to first edge
    logic [9:0] t2c1;   // final edge to chip select release
    logic       lead_f; // waiting for the first edge
    logic       trl_f;  // waiting for the release
    logic [9:0] lead_c;
    logic [9:0] trl_c;
    logic [9:0] gap_c;  // cycles since the last clock edge

    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (SRST);

    assign pol  = FORMAT_REG[FMT_POL_BIT];
    assign on   = GLOBAL_CONTROL_REG[CTRL_EN_BIT] & FORMAT_REG[FMT_PHASE_BIT];
    assign per  = (FORMAT_REG[15:8] == 8'h00) ? PRESC0_PERIOD : {2'h0, FORMAT_REG[15:8]} + 10'h001;
    assign lead = (per >> 1) + {2'h0, DELAY_REG[31:24]}
                + ((CS_HOLD_BETWEEN_WORDS & pol) ? LEAD_EXTRA_HLD : LEAD_EXTRA);
    assign t2c1 = {2'h0, DELAY_REG[23:16]} + TRAIL_EXTRA;

    // counters kept here because delays reach past what a plain delay may span
    always_ff @(posedge CLOCK) begin
        if (SRST) begin
            lead_f <= 1'b0;
            trl_f  <= 1'b0;
            lead_c <= 10'h000;
            trl_c  <= 10'h000;
            gap_c  <= 10'h000;
        end else begin
            gap_c  <= $changed(SERIAL_CLOCK_PIN) ? 10'h001 : gap_c + 10'h001;
            lead_c <= $fell(CS_N) ? 10'h001 : lead_c + 10'h001;
            trl_c  <= RX_VALID ? 10'h001 : trl_c + 10'h001;
            lead_f <= $fell(CS_N) | (lead_f & ~CS_N & ~$changed(SERIAL_CLOCK_PIN));
            trl_f  <= RX_VALID | (trl_f & ~CS_N);
        end
    end

    chk_lead_time: assert property (lead_f |-> lead_c <= lead
        && ($changed(SERIAL_CLOCK_PIN) == (lead_c == lead))) else $error("lead time off");
    chk_trail_time: assert property (trl_f && !CS_HOLD_BETWEEN_WORDS |-> trl_c <= t2c1
        && ($rose(CS_N) == (trl_c == t2c1))) else $error("chip select release off");
    chk_first_half: assert property ($changed(SERIAL_CLOCK_PIN)
        && SERIAL_CLOCK_PIN == pol && !CS_N |-> gap_c == (per >> 1)) else $error("half period off");
    chk_off_idle: assert property (!on |=> CS_N && !CONTROLLER_OUT_OE)
        else $error("started while disabled");
    chk_on_drive: assert property (on |=> CONTROLLER_OUT_OE)
        else $error("pins not driven");
    chk_launch_edge: assert property (!CS_N && !$past(CS_N)
        && $changed(CONTROLLER_OUT_LINE) |-> $changed(SERIAL_CLOCK_PIN)
        && SERIAL_CLOCK_PIN != pol) else $error("data moved off the leading edge");
    chk_rx_final: assert property (RX_VALID |-> $changed(SERIAL_CLOCK_PIN)
        && SERIAL_CLOCK_PIN == pol) else $error("word done off the final edge");
    chk_idle_clock: assert property (CS_N && $past(CS_N) && !$past(SRST)
        && $stable(FORMAT_REG) |-> SERIAL_CLOCK_PIN == pol) else $error("idle level wrong");

    cover property ($fell(CS_N) && CS_HOLD_BETWEEN_WORDS && pol);
    cover property (RX_VALID && trl_f);
    cover property (!TX_READY);
endmodule // spict_checker

bind spict_top spict_checker spict_checker_inst (.CLOCK(CLOCK), .SRST(SRST),
    .GLOBAL_CONTROL_REG(GLOBAL_CONTROL_REG), .FORMAT_REG(FORMAT_REG), .DELAY_REG(DELAY_REG),
    .CS_HOLD_BETWEEN_WORDS(CS_HOLD_BETWEEN_WORDS), .TX_READY(TX_READY), .RX_VALID(RX_VALID),
    .SERIAL_CLOCK_PIN(SERIAL_CLOCK_PIN), .CONTROLLER_OUT_LINE(CONTROLLER_OUT_LINE),
    .CONTROLLER_OUT_OE(CONTROLLER_OUT_OE), .CS_N(CS_N));

/* File: verification/spict_peripheral.sv */
// behavioural serial peripheral, clock phase 1, 16-bit words
`timescale 1ns/1ps
module spict_peripheral (
    input  wire logic        SCLK,
    input  wire logic        CS_N,
    input  wire logic        POL,
    input  wire logic        MOSI,
    input  wire logic [15:0] REPLY,
    output logic             MISO,
    output logic [15:0]      GOT
);
    logic [15:0] sh; // reply bits still to go
    int          n;  // leading edges seen in this word
    initial begin
        MISO = 1'b0;
        GOT  = 16'h0000;
    end
    // released line shows the inverse, never a stale value
    always @(posedge CS_N) MISO <= #1 ~MISO;
    always @(negedge CS_N) n = 0;
    // launch on the leading edge, sample on the trailing edge
    always @(SCLK) if (!CS_N) begin
        if (SCLK !== POL) begin
            if (n == 0) sh = REPLY;
            MISO <= #1 sh[15];
            sh = sh << 1;
            n = (n + 1) % 16;
        end else GOT = {GOT[14:0], MOSI};
    end
endmodule // spict_peripheral

/* File: verification/spict_top_bench.sv */
// self-checking bench for the clock-phase-1 serial controller
`timescale 1ns/1ps
module spict_top_bench;
    import spict_pkg::*;
    logic        clock, srst, hold, tx_valid, tx_ready, rx_valid, busy;
    logic        sclk, mosi, oe, miso, cs_n, cs_q, sclk_q;
    logic [31:0] gcr, fmt, dly;
    logic [15:0] tx_data, rx_data, reply, got;
    int          num_errors, tests_run, cyc, t_fall, t_rise, n_fall, k;
    int          ev[$]; // cycles of clock edges in the current frame

    spict_top spict_top_inst (.CLOCK(clock), .SRST(srst), .GLOBAL_CONTROL_REG(gcr),
        .FORMAT_REG(fmt), .DELAY_REG(dly), .CS_HOLD_BETWEEN_WORDS(hold), .TX_DATA(tx_data),
        .TX_VALID(tx_valid), .TX_READY(tx_ready), .RX_DATA(rx_data), .RX_VALID(rx_valid),
        .BUSY(busy), .SERIAL_CLOCK_PIN(sclk), .CONTROLLER_OUT_LINE(mosi),
        .CONTROLLER_OUT_OE(oe), .CONTROLLER_IN_LINE(miso), .CS_N(cs_n));
    spict_peripheral spict_peripheral_inst (.SCLK(sclk), .CS_N(cs_n), .POL(fmt[17]),
        .MOSI(mosi), .REPLY(reply), .MISO(miso), .GOT(got));

    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end
    always @(posedge clock) cyc <= cyc + 1;

    // log frame events mid-cycle, where outputs have settled
    always @(negedge clock) begin
        if (cs_q && !cs_n) begin
            t_fall = cyc;
            n_fall++;
            ev.delete();
        end
        if (!cs_n && sclk !== sclk_q) ev.push_back(cyc);
        if (!cs_q && cs_n) t_rise = cyc;
        cs_q   = cs_n;
        sclk_q = sclk;
    end

    task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task stop_test;
        $display("errors %0d checks %0d", num_errors, tests_run);
        if (num_errors == 0 && tests_run > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    // offer a word and hold it until taken; valid stays up for the caller
    task push(input logic [15:0] w);
        tx_data  = w;
        tx_valid = 1'b1;
        @(negedge clock);
        while (tx_ready !== 1'b1) @(negedge clock);
        @(posedge clock);
        #1;
    endtask

    // one word with a given format, then every timing and both data paths
    task automatic xfer(input logic [7:0] presc, c2t, t2c, input logic pol, hv,
                        input logic [15:0] w, r);
        int p;
        int h1;
        p  = (presc == 8'h00) ? 2 : presc + 1;
        h1 = p / 2;
        @(posedge clock);
        #1 fmt = {14'h0, pol, 1'b1, presc, 8'h00};
        dly    = {c2t, t2c, 16'h0000};
        hold   = hv;
        reply  = r;
        t_rise = 0;
        push(w);
        tx_valid = 1'b0;
        for (k = 0; k < 9000 && t_rise == 0; k++) @(negedge clock);
        check("lead", ev[0] - t_fall, h1 + c2t + ((hv && pol) ? 3 : 2));
        check("half", ev[1] - ev[0], h1);
        check("period", ev[2] - ev[0], p);
        check("edges", ev.size(), 32);
        check("trail", t_rise - ev[31], t2c + 1);
        check("rx", rx_data, r);
        check("got", got, w);
        check("idle", sclk, pol);
        check("busy", busy, 1'b0);
    endtask

    initial begin
        #400000;
        num_errors++;
        stop_test;
    end

    initial begin
        srst     = 1'b1;
        gcr      = 32'h0000_0000;
        fmt      = 32'h0002_0000;
        dly      = 32'h0000_0000;
        hold     = 1'b0;
        tx_valid = 1'b0;
        tx_data  = 16'h0000;
        reply    = 16'h0000;
        repeat (8) @(posedge clock);
        #1 srst = 1'b0;
        @(negedge clock);
        check("oe", oe, 1'b0);
        // fill the queue while disabled, then offer a ninth that must be refused
        @(posedge clock);
        #1;
        for (int i = 0; i < 8; i++) push(16'h1000 + i);
        tx_data = 16'hDEAD;
        @(negedge clock);
        check("ready", tx_ready, 1'b0);
        repeat (3) @(posedge clock);
        #1 tx_valid = 1'b0;
        gcr = 32'h0000_0001;
        repeat (20) @(posedge clock);
        #1 check("phase0", n_fall, 0);
        check("oe0", oe, 1'b0);
        fmt   = 32'h0003_0000;
        dly   = 32'h0102_0000;
        hold  = 1'b1;
        reply = 16'h5A0F;
        // drain with hold: one frame carries all eight words in order
        for (int i = 0; i < 8; i++) begin
            for (k = 0; k < 300 && rx_valid !== 1'b1; k++) @(negedge clock);
            check("word", got, 16'h1000 + i);
            check("reply", rx_data, 16'h5A0F);
            check("busy1", busy, 1'b1);
            @(negedge clock);
        end
        for (k = 0; k < 300 && cs_n !== 1'b1; k++) @(negedge clock);
        check("frames", n_fall, 1);
        check("oe1", oe, 1'b1);
        xfer(8'h00, 8'h00, 8'h00, 1'b0, 1'b0, 16'h8001, 16'h7FFE);
        xfer(8'h01, 8'h02, 8'h03, 1'b1, 1'b0, 16'hA5C3, 16'h3CA5);
        xfer(8'h04, 8'h01, 8'h00, 1'b1, 1'b1, 16'h0F0F, 16'hF001);
        xfer(8'h05, 8'h00, 8'h01, 1'b0, 1'b1, 16'h1234, 16'h8421);
        xfer(8'hFF, 8'hFF, 8'hFF, 1'b0, 1'b0, 16'hFFFE, 16'h0001);
        stop_test;
    end
endmodule // spict_top_bench
